//--- bench/ptm_pin_model.sv
/*
 * Far-side model of the low-half external clock / gate pin.
 * Assumes the bench pulses go for one cycle and waits on busy.
 */
`timescale 1ns/10ps
module ptm_pin_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [31:0] n,
    input  wire logic [31:0] hp,
    output logic             pin,
    output logic             busy
);
    // n rising edges, each low then high for hp cycles
    initial begin
        pin  = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go && !busy) begin
                busy <= 1'b1;
                repeat (n) begin
                    repeat (hp) @(posedge clk);
                    pin <= 1'b1;
                    repeat (hp) @(posedge clk);
                    pin <= 1'b0;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

//--- bench/tb.sv
/*
 * Self-checking bench of the timer pair over APB.
 * Waits on PREADY in a bounded loop; the pin model drives the low pin.
 */
`timescale 1ns/10ps
module tb;
    import ptm_pkg::*;
    logic CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [11:0] PADDR = 0;
    logic [31:0] PWDATA = 0, PRDATA;
    logic PREADY, PSLVERR, ADC_TRIGGER, PAIR_IRQ, IDLE = 0, SLEEP = 0;
    logic EXT_PIN_LO, go = 0, busy;
    logic [15:0] d1, d2, tbl, tbh;
    logic [32:0] q[$];
    int err_total = 0, samples_checked = 0, seed = 42075, n, hp = 6, k;
    int dv[4] = '{1, 8, 64, 256};

    always #25 CLK = ~CLK;

    ptm_timer_pair i_ptm_timer_pair (.CLK(CLK), .RESET_N(RESET_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .EXT_PIN_LO(EXT_PIN_LO), .EXT_PIN_HI(1'b0),
        .IDLE(IDLE), .SLEEP(SLEEP), .ADC_TRIGGER(ADC_TRIGGER),
        .PAIR_IRQ(PAIR_IRQ), .TIMEBASE_LO(tbl), .TIMEBASE_HI(tbh));
    ptm_pin_model i_ptm_pin_model (.clk(CLK), .go(go), .n(n), .hp(hp),
        .pin(EXT_PIN_LO), .busy(busy));

    task automatic print_verdict;
        if (err_total == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [32:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic fail(input string nm);
        chk(nm, 33'h1, 33'h0);
        print_verdict();
    endtask
    // read expectation {PSLVERR, PRDATA} goes to the queue
    task automatic apb(input logic w, input logic [9:0] ix,
                       input logic [15:0] d, input logic [32:0] e);
        int t;
        @(posedge CLK);
        PSEL <= 1'b1; PWRITE <= w; PADDR <= {ix, 2'h0};
        PWDATA <= {16'h0, d};
        if (!w) q.push_back(e);
        @(posedge CLK);
        PENABLE <= 1'b1;
        t = 0;
        do begin
            @(posedge CLK);
            t++;
        end while (PREADY !== 1'b1 && t < 20);
        PSEL <= 1'b0; PENABLE <= 1'b0;
        if (t >= 20) fail("pready");
    endtask
    task automatic wr(input logic [9:0] ix, input logic [15:0] d);
        apb(1'b1, ix, d, 33'h0);
    endtask
    task automatic rd(input logic [9:0] ix, input logic [32:0] e);
        apb(1'b0, ix, 16'h0, e);
    endtask
    // cycles between two trigger pulses
    task automatic meas(input int e);
        int t;
        t = 0;
        while (ADC_TRIGGER !== 1'b1 && t < 2000) begin
            @(posedge CLK);
            t++;
        end
        if (t >= 2000) fail("trigger");
        t = 0;
        do begin
            @(posedge CLK);
            t++;
        end while (ADC_TRIGGER !== 1'b1 && t < 2000);
        chk("trigger gap", 33'(e), 33'(t));
        if (t >= 2000) fail("trigger gap");
    endtask
    task automatic zero_count;
        wr(IDX_LO_CTRL, 16'h0008);
        wr(IDX_HOLDING, 16'h0000);
        wr(IDX_LO_COUNT, 16'h0000);
    endtask
    task automatic pins(input int cnt);
        int t;
        n <= cnt;
        go <= 1'b1;
        @(posedge CLK);
        go <= 1'b0;
        @(posedge CLK);
        t = 0;
        while (busy !== 1'b0 && t < 5000) begin
            @(posedge CLK);
            t++;
        end
        if (t >= 5000) fail("pin model");
        repeat (10) @(posedge CLK);
    endtask

    always @(posedge CLK)
        if (PSEL && PENABLE && PREADY && !PWRITE && q.size() > 0)
            chk("read", q.pop_front(), {PSLVERR, PRDATA});

    initial begin
        n = 0;
        repeat (6) @(posedge CLK);
        RESET_N <= 1'b1;
        rd(IDX_LO_PERIOD, 33'h0FFFF);
        rd(IDX_HI_PERIOD, 33'h0FFFF);
        rd(IDX_LO_CTRL, 33'h0);
        rd(10'h3FF, 33'h100000000);
        wr(IDX_LO_CTRL, 16'hFFFF);
        rd(IDX_LO_CTRL, 33'h0A07A);
        wr(IDX_LO_CTRL, 16'h0000);
        rd(IDX_LO_COUNT, 33'h0);
        d1 = 16'($random(seed));
        d2 = 16'($random(seed));
        wr(IDX_LO_CTRL, 16'h0008);
        wr(IDX_HOLDING, d1);
        wr(IDX_LO_COUNT, d2);
        rd(IDX_HI_COUNT, {17'h0, d1});
        wr(IDX_HI_COUNT, d2);
        rd(IDX_LO_COUNT, {17'h0, d2});
        rd(IDX_HOLDING, {17'h0, d2});
        wr(IDX_LO_CTRL, 16'h0000);
        wr(IDX_HOLDING, d1);
        wr(IDX_LO_COUNT, d1);
        rd(IDX_HI_COUNT, {17'h0, d2});
        zero_count();
        IDLE <= 1'b1;
        wr(IDX_LO_CTRL, 16'hA008);
        repeat (30) @(posedge CLK);
        wr(IDX_LO_CTRL, 16'h0008);
        rd(IDX_LO_COUNT, 33'h0);
        IDLE <= 1'b0;
        SLEEP <= 1'b1;
        wr(IDX_LO_CTRL, 16'h8008);
        repeat (30) @(posedge CLK);
        wr(IDX_LO_CTRL, 16'h0008);
        rd(IDX_LO_COUNT, 33'h0);
        SLEEP <= 1'b0;
        wr(IDX_LO_PERIOD, 16'h0001);
        wr(IDX_HI_PERIOD, 16'h0000);
        wr(IDX_IRQ_STAT, 16'h0100);
        wr(IDX_HI_CTRL, 16'h0030);
        for (k = 0; k < 4; k++) begin
            IDLE <= (k == 2);
            zero_count();
            wr(IDX_LO_CTRL, 16'h8008 | 16'(k << 4));
            meas(2 * dv[k]);
        end
        wr(IDX_LO_CTRL, 16'h0008);
        chk("irq", 33'h1, {32'h0, PAIR_IRQ});
        rd(IDX_IRQ_STAT, 33'h00101);
        wr(IDX_IRQ_STAT, 16'h0100);
        rd(IDX_IRQ_STAT, 33'h00100);
        wr(IDX_LO_PERIOD, 16'hFFFF);
        wr(IDX_HI_PERIOD, 16'hFFFF);
        zero_count();
        wr(IDX_LO_CTRL, 16'h800A);
        pins(5);
        wr(IDX_LO_CTRL, 16'h0008);
        rd(IDX_LO_COUNT, 33'h5);
        chk("timebase", 33'h5, {1'b0, tbh, tbl});
        zero_count();
        wr(IDX_LO_CTRL, 16'h8048);
        repeat (20) @(posedge CLK);
        rd(IDX_LO_COUNT, 33'h0);
        pins(1);
        wr(IDX_LO_CTRL, 16'h0008);
        rd(IDX_LO_COUNT, 33'h6);
        rd(IDX_IRQ_STAT, 33'h00101);
        repeat (5) @(posedge CLK);
        print_verdict();
    end
endmodule

//--- core/ptm_pkg.sv
/*
 * Shared constants, field layout and types of the paired timer.
 * Assumes a 32-bit APB slave port with a 12-bit byte address.
 */
package ptm_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_LO_COUNT  = 10'h106;
    localparam logic [9:0] IDX_HOLDING   = 10'h108;
    localparam logic [9:0] IDX_HI_COUNT  = 10'h10A;
    localparam logic [9:0] IDX_LO_PERIOD = 10'h10C;
    localparam logic [9:0] IDX_HI_PERIOD = 10'h10E;
    localparam logic [9:0] IDX_LO_CTRL   = 10'h110;
    localparam logic [9:0] IDX_HI_CTRL   = 10'h112;
    localparam logic [9:0] IDX_IRQ_STAT  = 10'h120;

    // ------------------------------------------------------------------
    // reset values, masks and count maximum
    // ------------------------------------------------------------------
    localparam logic [15:0] PERIOD_RST   = 16'hFFFF;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] COUNT_RST    = 16'h0000;
    localparam logic [15:0] CTRL_LO_MASK = 16'hA07A;
    localparam logic [15:0] CTRL_HI_MASK = 16'hA072;
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_ON       = 15;
    localparam int BIT_SIDL     = 13;
    localparam int BIT_GATE     = 6;
    localparam int BIT_PS       = 4;
    localparam int BIT_CASCADE  = 3;
    localparam int BIT_CS       = 1;
    localparam int BIT_FLAG_PR  = 0;
    localparam int BIT_FLAG_LO  = 1;
    localparam int BIT_EN_PR    = 8;
    localparam int BIT_EN_LO    = 9;

    // ------------------------------------------------------------------
    // prescale terminal counts
    // ------------------------------------------------------------------
    localparam logic [7:0] PS_LAST_1   = 8'h00;
    localparam logic [7:0] PS_LAST_8   = 8'h07;
    localparam logic [7:0] PS_LAST_64  = 8'h3F;
    localparam logic [7:0] PS_LAST_256 = 8'hFF;

    typedef struct packed {
        logic       on;
        logic       sidl;
        logic       gate;
        logic [1:0] ps;
        logic       cascade;
        logic       cs;
    } ptm_ctrl_s;

    function automatic ptm_ctrl_s ptm_fields(input logic [15:0] w);
        ptm_ctrl_s c;
        c.on      = w[BIT_ON];
        c.sidl    = w[BIT_SIDL];
        c.gate    = w[BIT_GATE];
        c.ps      = w[BIT_PS+1:BIT_PS];
        c.cascade = w[BIT_CASCADE];
        c.cs      = w[BIT_CS];
        return c;
    endfunction

    function automatic logic [7:0] ptm_ps_last(input logic [1:0] ps);
        case (ps)
            2'h0:    return PS_LAST_1;
            2'h1:    return PS_LAST_8;
            2'h2:    return PS_LAST_64;
            default: return PS_LAST_256;
        endcase
    endfunction

endpackage

//--- core/ptm_prescaler.sv
/*
 * Clock prescaler of one timer half.
 * Assumes tick_in is a one-cycle enable in the system clock domain.
 */
`timescale 1ns/10ps
module ptm_prescaler
    import ptm_pkg::*;
#(
    parameter bit SYNC_OUT = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic       clear,
    input  wire logic [1:0] ps,
    input  wire logic       tick_in,
    output logic            tick_out
);

    logic [7:0] cnt;
    logic       hit;

    assign hit = run & tick_in & (cnt == ptm_ps_last(ps));

    // counter halts while not running, so it keeps its value
    always_ff @(posedge clk) begin
        if (!reset_n || clear) begin
            cnt <= 8'h00;
        end else if (run && tick_in) begin
            cnt <= hit ? 8'h00 : cnt + 8'h01;
        end
    end

    // resynchronised output costs one cycle of latency
    generate
        if (SYNC_OUT) begin : g_sync
            logic tick_q;
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    tick_q <= 1'b0;
                end else begin
                    tick_q <= hit;
                end
            end
            assign tick_out = tick_q;
        end else begin : g_direct
            assign tick_out = hit;
        end
    endgenerate

endmodule

//--- core/ptm_timer_pair.sv
/*
 * Timer pair: two 16-bit timers or one cascaded 32-bit timer/counter,
 * with an APB register slave, holding register and match events.
 * Assumes IDLE and SLEEP come from the core's power control, and the
 * external pins are synchronised here before use.
 */
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module ptm_timer_pair
    import ptm_pkg::*;
#(
    parameter bit ADC_TRIG_EN = 1'b1
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        EXT_PIN_LO,
    input  wire logic        EXT_PIN_HI,
    input  wire logic        IDLE,
    input  wire logic        SLEEP,
    output logic             ADC_TRIGGER,
    output logic             PAIR_IRQ,
    output logic      [15:0] TIMEBASE_LO,
    output logic      [15:0] TIMEBASE_HI
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [15:0] lo_count;
    logic [15:0] hi_count;
    logic [15:0] holding;
    logic [15:0] lo_period;
    logic [15:0] hi_period;
    logic [15:0] lo_ctrl;
    logic [15:0] hi_ctrl;
    logic [1:0]  flags;
    logic [1:0]  enables;
    logic        lo_on_q;
    logic        hi_on_q;
    logic [2:0]  pin_lo_s;
    logic [2:0]  pin_hi_s;

    function automatic logic [15:0] cnt_next(input logic [15:0] c,
                                             input logic [15:0] p);
        return (c == p) ? 16'h0000 : c + 16'h0001;
    endfunction

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic [9:0] idx;
    logic       setup;
    logic       wr;
    logic       rd_setup;
    logic       mapped;
    logic       wr_lo_cnt;
    logic       wr_hi_cnt;
    logic       wr_cnt;
    logic [15:0] wdata16;

    assign idx      = PADDR[11:2];
    assign setup    = PSEL & ~PENABLE;
    assign wr       = PSEL & PENABLE & PWRITE & PREADY;
    assign rd_setup = setup & ~PWRITE;
    assign wdata16  = PWDATA[15:0];
    assign wr_lo_cnt = wr & (idx == IDX_LO_COUNT);
    assign wr_hi_cnt = wr & (idx == IDX_HI_COUNT);
    assign wr_cnt    = wr_lo_cnt | wr_hi_cnt;

    always_comb begin
        case (idx)
            IDX_LO_COUNT, IDX_HOLDING, IDX_HI_COUNT, IDX_LO_PERIOD,
            IDX_HI_PERIOD, IDX_LO_CTRL, IDX_HI_CTRL,
            IDX_IRQ_STAT: mapped = 1'b1;
            default:      mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------------
    ptm_ctrl_s cl;
    ptm_ctrl_s ch;
    logic      cascade;
    logic      halt_lo;
    logic      halt_hi;
    logic      run_lo;
    logic      run_hi;
    logic      in_lo;
    logic      in_hi;
    logic      tick_lo;
    logic      tick_hi;
    logic      gate_lvl;
    logic      gate_fall_lo;
    logic      gate_fall_hi;
    logic      clr_lo;
    logic      clr_hi;
    logic [31:0] count32;
    logic [31:0] period32;
    logic      match32;
    logic      adc_ev;
    logic      ev_pair;
    logic      ev_lo;

    assign cl = ptm_fields(lo_ctrl);
    assign ch = ptm_fields(hi_ctrl);
    assign cascade = cl.cascade;

    assign halt_lo = SLEEP | (IDLE & cl.sidl);
    assign halt_hi = SLEEP | (IDLE & ch.sidl);
    assign run_lo  = cl.on & ~halt_lo;
    assign run_hi  = ~cascade & ch.on & ~halt_hi;

    // gate counts only while pin high
    assign gate_lvl = pin_lo_s[1];
    assign in_lo = cl.cs ? (pin_lo_s[1] & ~pin_lo_s[2])
                         : (cl.gate ? gate_lvl : 1'b1);
    // high half keeps its own modes
    assign in_hi = ch.cs ? (pin_hi_s[1] & ~pin_hi_s[2])
                         : (ch.gate ? pin_hi_s[1] : 1'b1);

    // gate fall ends accumulation, count kept
    assign gate_fall_lo = run_lo & cl.gate & ~cl.cs
                        & ~pin_lo_s[1] & pin_lo_s[2];
    assign gate_fall_hi = run_hi & ch.gate & ~ch.cs
                        & ~pin_hi_s[1] & pin_hi_s[2];

    // clear on count write or timer-on fall
    // a count write does not clear while the timer is off
    assign clr_lo = (wr_cnt & cl.on) | (lo_on_q & ~cl.on);
    assign clr_hi = (wr_cnt & ch.on) | (hi_on_q & ~ch.on);

    // low half is the lower word
    assign count32  = {hi_count, lo_count};
    assign period32 = {hi_period, lo_period};
    assign match32  = (count32 == period32);
    assign adc_ev   = ADC_TRIG_EN & cascade & tick_lo & match32;

    // 32-bit or high-half match or gate fall raises pair flag
    // cascaded events use the pair flag
    assign ev_pair = (cascade & tick_lo & match32)
                   | (cascade & gate_fall_lo)
                   | (~cascade & tick_hi & (hi_count == hi_period))
                   | (~cascade & gate_fall_hi);
    assign ev_lo   = ~cascade
                   & ((tick_lo & (lo_count == lo_period)) | gate_fall_lo);

    // ------------------------------------------------------------------
    // prescalers
    // ------------------------------------------------------------------
    // only the low half resynchronises
    ptm_prescaler #(
        .SYNC_OUT (1'b1)
    ) u_ps_lo (
        .clk      (CLK),
        .reset_n  (RESET_N),
        .run      (run_lo),
        .clear    (clr_lo),
        .ps       (cl.ps),
        .tick_in  (in_lo),
        .tick_out (tick_lo)
    );

    ptm_prescaler #(
        .SYNC_OUT (1'b0)
    ) u_ps_hi (
        .clk      (CLK),
        .reset_n  (RESET_N),
        .run      (run_hi),
        .clear    (clr_hi),
        .ps       (ch.ps),
        .tick_in  (in_hi),
        .tick_out (tick_hi)
    );

    // ------------------------------------------------------------------
    // pin synchronisers and edge history
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            pin_lo_s <= 3'h0;
            pin_hi_s <= 3'h0;
            lo_on_q  <= 1'b0;
            hi_on_q  <= 1'b0;
        end else begin
            pin_lo_s <= {pin_lo_s[1:0], EXT_PIN_LO};
            pin_hi_s <= {pin_hi_s[1:0], EXT_PIN_HI};
            lo_on_q  <= cl.on;
            hi_on_q  <= ch.on;
        end
    end

    // ------------------------------------------------------------------
    // counts
    // ------------------------------------------------------------------
    // control writes never reach the counts
    // cascaded count wraps at combined period
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            lo_count <= COUNT_RST;
        end else if (wr_lo_cnt) begin
            lo_count <= wdata16;
        end else if (tick_lo) begin
            lo_count <= cascade ? (match32 ? 16'h0000 : lo_count + 16'h0001)
                                : cnt_next(lo_count, lo_period);
        end
    end

    // holding moves into high on low write in cascade only
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            hi_count <= COUNT_RST;
        end else if (wr_lo_cnt && cascade) begin
            hi_count <= holding;
        end else if (wr_hi_cnt) begin
            hi_count <= wdata16;
        end else if (cascade && tick_lo) begin
            if (match32) begin
                hi_count <= 16'h0000;
            end else if (lo_count == COUNT_MAX) begin
                hi_count <= hi_count + 16'h0001;
            end
        end else if (!cascade && tick_hi) begin
            hi_count <= cnt_next(hi_count, hi_period);
        end
    end

    // low count read latches high count
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            holding <= COUNT_RST;
        end else if (wr && idx == IDX_HOLDING) begin
            holding <= wdata16;
        end else if (rd_setup && idx == IDX_LO_COUNT) begin
            holding <= hi_count;
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    // unimplemented control bits stay zero
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            lo_period <= PERIOD_RST;
            hi_period <= PERIOD_RST;
            lo_ctrl   <= CTRL_RST;
            hi_ctrl   <= CTRL_RST;
        end else if (wr) begin
            if (idx == IDX_LO_PERIOD) lo_period <= wdata16;
            if (idx == IDX_HI_PERIOD) hi_period <= wdata16;
            if (idx == IDX_LO_CTRL)   lo_ctrl <= wdata16 & CTRL_LO_MASK;
            if (idx == IDX_HI_CTRL)   hi_ctrl <= wdata16 & CTRL_HI_MASK;
        end
    end

    // set wins over a software clear
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            flags   <= 2'h0;
            enables <= 2'h0;
        end else begin
            if (wr && idx == IDX_IRQ_STAT) begin
                flags[0] <= ev_pair | (flags[0] & PWDATA[BIT_FLAG_PR]);
                flags[1] <= ev_lo | (flags[1] & PWDATA[BIT_FLAG_LO]);
                enables  <= {PWDATA[BIT_EN_LO], PWDATA[BIT_EN_PR]};
            end else begin
                flags <= flags | {ev_lo, ev_pair};
            end
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup;
            PSLVERR <= setup & ~mapped;
            if (rd_setup) begin
                case (idx)
                    IDX_LO_COUNT:  PRDATA <= {16'h0000, lo_count};
                    IDX_HOLDING:   PRDATA <= {16'h0000, holding};
                    IDX_HI_COUNT:  PRDATA <= {16'h0000, hi_count};
                    IDX_LO_PERIOD: PRDATA <= {16'h0000, lo_period};
                    IDX_HI_PERIOD: PRDATA <= {16'h0000, hi_period};
                    IDX_LO_CTRL:   PRDATA <= {16'h0000, lo_ctrl};
                    IDX_HI_CTRL:   PRDATA <= {16'h0000, hi_ctrl};
                    IDX_IRQ_STAT:  PRDATA <= {22'h0, enables, 6'h0, flags};
                    default:       PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // time bases for capture and compare
    // pair without trigger still drives these
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ADC_TRIGGER <= 1'b0;
            PAIR_IRQ    <= 1'b0;
            TIMEBASE_LO <= COUNT_RST;
            TIMEBASE_HI <= COUNT_RST;
        end else begin
            ADC_TRIGGER <= adc_ev;
            PAIR_IRQ    <= |(flags & enables);
            TIMEBASE_LO <= lo_count;
            TIMEBASE_HI <= hi_count;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    property p_casc_wrap;
        cascade && tick_lo && match32 && !wr_cnt |=> count32 == 32'h0;
    endproperty
    a_casc_wrap: assert property (p_casc_wrap)
        else $error("32-bit count did not wrap on match");

    property p_casc_inc;
        cascade && tick_lo && !match32 && !wr_cnt
            |=> count32 == $past(count32) + 32'h1;
    endproperty
    a_casc_inc: assert property (p_casc_inc)
        else $error("32-bit count did not carry into high word");

    property p_hold_cap;
        rd_setup && idx == IDX_LO_COUNT |=> holding == $past(hi_count);
    endproperty
    a_hold_cap: assert property (p_hold_cap)
        else $error("holding missed high count on low read");

    property p_hold_xfer;
        wr_lo_cnt && cascade
            |=> hi_count == $past(holding) && lo_count == $past(wdata16);
    endproperty
    a_hold_xfer: assert property (p_hold_xfer)
        else $error("holding not moved into high count");

    property p_idle_stop;
        (IDLE && cl.sidl && !wr_cnt) [*2] |=> $stable(lo_count);
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("low count moved during stopped idle");

    property p_gate_low;
        (cl.gate && !cl.cs && !gate_lvl && !wr_cnt) [*2]
            |=> $stable(lo_count);
    endproperty
    a_gate_low: assert property (p_gate_low)
        else $error("count moved while gate low");

    property p_sleep;
        (SLEEP && !wr_cnt) [*2] |=> $stable(count32);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("count moved in sleep");

    property p_adc;
        ADC_TRIGGER |-> $past(cascade && match32)
            && (count32 == 32'h0 || $past(wr_cnt));
    endproperty
    a_adc: assert property (p_adc)
        else $error("trigger without 32-bit match");

    property p_flag;
        cascade && tick_lo && match32
            |=> flags[0] ##1
                PAIR_IRQ == $past(enables[0] | (flags[1] & enables[1]));
    endproperty
    a_flag: assert property (p_flag)
        else $error("pair flag or request missing after match");

    property p_ctrl_rsv;
        (lo_ctrl & ~CTRL_LO_MASK) == 16'h0
            && (hi_ctrl & ~CTRL_HI_MASK) == 16'h0;
    endproperty
    a_ctrl_rsv: assert property (p_ctrl_rsv)
        else $error("unimplemented control bit set");

    c_wrap: cover property (cascade && tick_lo && match32);
    c_gate: cover property (gate_fall_lo);
    c_hold: cover property (rd_setup && idx == IDX_LO_COUNT && cascade);
    c_hi16: cover property (!cascade && tick_hi && hi_count == hi_period);

endmodule
